// ### dow_consts.svh
// constants for the device option word decoder
`ifndef DOW_CONSTS_SVH
`define DOW_CONSTS_SVH

// ==========================================================
// address map
`define DOW_OPTION_ADDR   14'h2007
`define DOW_TEST_LO       14'h2000
`define DOW_TEST_HI       14'h3FFF
`define DOW_LOW_PAGE_TOP  13'h003F
`define DOW_PROG_WORDS    14'h1000

// ==========================================================
// option word fields
`define DOW_WORD_ERASED   14'h3FFF
`define DOW_OSC_HI        1
`define DOW_OSC_LO        0
`define DOW_WDT_BIT       2
`define DOW_POWERUP_DELAY_TIMER_BIT      3
`define DOW_BOR_BIT       6
`define DOW_UNIMPL_BIT    7
`define DOW_PROT_NONE_FROM 13'h0FFF

// ==========================================================
// option values before the first capture
`define DOW_RST_WDT       1'b1
`define DOW_RST_POWERUP_DELAY_TIMER      1'b0
`define DOW_RST_BOR       1'b1
`define DOW_RST_LOW_PAGE  1'b0
`define DOW_RST_CONSIST   1'b1

// ==========================================================
// timing
`define DOW_POWERUP_DELAY_TIMER_MS       72
`define DOW_CLK_KHZ       125000
`define DOW_OST_EDGES     24'h000400

`endif

// ### dow_decode_monitor.sv
// assertion checker for the option word decoder
`timescale 1ns/1ps
module dow_decode_monitor
   import dow_pkg::*;
(
   // clock and reset
   input logic        clk,
   input logic        rst,
   // driven into the decoder
   input logic [13:0] storedWord,
   input logic        pairedLayout,
   input logic        progMode,
   input logic        progWrite,
   input logic [13:0] progAddr,
   input logic [13:0] progData,
   input logic        externalReset,
   input logic        watchdogWake,
   input logic        interruptWake,
   // driven by the decoder
   input logic        testSpaceWrite,
   input logic        optionWordWrite,
   input logic [13:0] optionWriteData,
   input logic [13:0] progReadData,
   input dow_osc_t    oscillatorSelect,
   input logic        crystalMode,
   input logic        externalClockAllowed,
   input logic        watchdogEnable,
   input logic        powerupDelayEnable,
   input logic        brownoutEnable,
   input dow_prot_t   protectLevel,
   input logic        lowPageWritable,
   input logic        chipReset,
   input logic        haltActive
);
   // ==========================================
   // properties
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   AST_DEC:
      assert property (!chipReset |-> {brownoutEnable, powerupDelayEnable,
         watchdogEnable, oscillatorSelect} == {storedWord[6],
         !storedWord[3] || storedWord[6], storedWord[2:0]}) else $error("dec");
   AST_PROT:
      assert property (!chipReset |-> protectLevel == (pairedLayout ?
         storedWord[5:4] : {2{storedWord[4]}}) && lowPageWritable ==
         (!pairedLayout && !storedWord[4])) else $error("prot");
   AST_XTAL:
      assert property (crystalMode == (oscillatorSelect != DOW_RC_MODE) &&
         externalClockAllowed == crystalMode) else $error("xtal");
   AST_HOLD:
      assert property (!$past(rst) && !$past(rst, 2) |-> $stable({protectLevel,
         oscillatorSelect, watchdogEnable, powerupDelayEnable, brownoutEnable}))
         else $error("hold");
   AST_OPT:
      assert property (progMode && progWrite && progAddr == 14'h2007 |=>
         optionWordWrite && testSpaceWrite && optionWriteData == $past(progData))
         else $error("opt");
   AST_REFUSE:
      assert property (progWrite && !(progMode && progAddr[13]) |=>
         !testSpaceWrite && !optionWordWrite) else $error("refuse");
   AST_RD:
      assert property (progMode && progAddr == 14'h2007 |=> progReadData ==
         ($past(storedWord) | {6'h0, $past(pairedLayout), 7'h0}))
         else $error("read");
   AST_WAKE:
      assert property (haltActive && (watchdogWake || interruptWake ||
         externalReset) |-> ##[1:2] !haltActive) else $error("wake");
   cover property ($fell(chipReset) && crystalMode);
   cover property (optionWordWrite);
   cover property ($fell(haltActive));
endmodule

bind dow_decoder dow_decode_monitor u_mon (.*);

// ### dow_decoder.sv
// option word decode and reset release sequencing
`timescale 1ns/1ps
`include "dow_consts.svh"

module dow_decoder
   import dow_pkg::*;
#(
   parameter int POWERUP_DELAY_TIMER_CYCLES = `DOW_POWERUP_DELAY_TIMER_MS * `DOW_CLK_KHZ
)(
   // clock and power-on reset
   input  wire logic        clk,
   input  wire logic        rst,
   // non-volatile option word and layout strap
   input  wire logic [13:0] storedWord,
   input  wire logic        pairedLayout,
   // programmer access
   input  wire logic        progMode,
   input  wire logic        progWrite,
   input  wire logic [13:0] progAddr,
   input  wire logic [13:0] progData,
   output logic             testSpaceWrite,
   output logic             optionWordWrite,
   output logic [13:0]      optionWriteData,
   output logic [13:0]      progReadData,
   // reset and wake sources
   input  wire logic        oscillatorInputPin,
   input  wire logic        externalReset,
   input  wire logic        brownoutDetect,
   input  wire logic        sleepRequest,
   input  wire logic        watchdogWake,
   input  wire logic        interruptWake,
   // decoded options
   output dow_osc_t         oscillatorSelect,
   output logic             crystalMode,
   output logic             externalClockAllowed,
   output logic             watchdogEnable,
   output logic             powerupDelayEnable,
   output logic             brownoutEnable,
   output dow_prot_t        protectLevel,
   output logic [12:0]      protectFromAddr,
   output logic             lowPageWritable,
   output logic             protectConsistent,
   // reset sequencing status
   output logic             chipReset,
   output logic             haltActive
);

   // ==========================================================
   // helpers
   function automatic logic isCrystal(input dow_osc_t m);
      isCrystal = (m != DOW_RC_MODE);
   endfunction

   function automatic logic inTestSpace(input logic [13:0] a);
      inTestSpace = (a >= `DOW_TEST_LO) && (a <= `DOW_TEST_HI);
   endfunction

   function automatic dow_state_t afterDelay(input dow_osc_t m);
      afterDelay = isCrystal(m) ? DOW_OSC_STARTUP : DOW_RUN;
   endfunction

   // unprotected still names the top word; read protectLevel first
   function automatic logic [12:0] protectStart(input dow_prot_t p);
      case (p)
         DOW_PROT_UPPER_HALF:
            protectStart = 13'(`DOW_PROG_WORDS >> 1);
         DOW_PROT_UPPER_3_4:
            protectStart = 13'(`DOW_PROG_WORDS >> 2);
         DOW_PROT_ALL:
            protectStart = 13'h0000;
         default:
            protectStart = `DOW_PROT_NONE_FROM;
      endcase
   endfunction

   // ==========================================================
   // decode of the stored word
   dow_osc_t    decOsc;
   dow_prot_t   decProt;
   logic        decWdt;
   logic        decBor;
   logic        decPwrt;
   logic        decConsistent;
   logic [12:0] decFrom;
   logic        decLowPage;

   always_comb begin
      decOsc = dow_osc_t'(storedWord[`DOW_OSC_HI:`DOW_OSC_LO]);
      decWdt = storedWord[`DOW_WDT_BIT];
      decBor = storedWord[`DOW_BOR_BIT];
      decPwrt = ~storedWord[`DOW_POWERUP_DELAY_TIMER_BIT] | decBor;
      decLowPage = 1'b0;
      if (pairedLayout) begin
         decConsistent = (storedWord[13:12] == storedWord[5:4]) &&
                         (storedWord[11:10] == storedWord[5:4]) &&
                         (storedWord[9:8] == storedWord[5:4]);
         decProt = dow_prot_t'(storedWord[5:4]);
      end else begin
         decConsistent = (storedWord[13:7] == {7{storedWord[4]}}) &&
                         (storedWord[5] == storedWord[4]);
         decProt = storedWord[4] ? DOW_PROT_NONE : DOW_PROT_ALL;
         decLowPage = ~storedWord[4];
      end
      decFrom = protectStart(decProt);
   end

   // ==========================================================
   // programmer port
   logic        next_testSpaceWrite;
   logic        next_optionWordWrite;
   logic [13:0] next_optionWriteData;
   logic [13:0] next_progReadData;

   always_comb begin
      next_testSpaceWrite = 1'b0;
      next_optionWordWrite = 1'b0;
      next_optionWriteData = optionWriteData;
      // reads outside the option word return zero
      next_progReadData = 14'h0000;
      // only reachable while programming
      if (progMode && inTestSpace(progAddr)) begin
         next_testSpaceWrite = progWrite;
         if (progAddr == `DOW_OPTION_ADDR) begin
            next_optionWordWrite = progWrite;
            if (progWrite) begin
               next_optionWriteData = progData;
            end
            next_progReadData = storedWord;
            if (pairedLayout) begin
               next_progReadData[`DOW_UNIMPL_BIT] = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         testSpaceWrite  <= 1'b0;
         optionWordWrite <= 1'b0;
         optionWriteData <= `DOW_WORD_ERASED;
         progReadData    <= 14'h0000;
      end else begin
         testSpaceWrite  <= next_testSpaceWrite;
         optionWordWrite <= next_optionWordWrite;
         optionWriteData <= next_optionWriteData;
         progReadData    <= next_progReadData;
      end
   end

   // ==========================================================
   // captured options
   dow_state_t  state;
   dow_state_t  next_state;
   dow_osc_t    next_oscillatorSelect;
   dow_prot_t   next_protectLevel;
   logic        next_watchdogEnable;
   logic        next_powerupDelayEnable;
   logic        next_brownoutEnable;
   logic [12:0] next_protectFromAddr;
   logic        next_lowPageWritable;
   logic        next_protectConsistent;

   always_comb begin
      next_oscillatorSelect   = oscillatorSelect;
      next_protectLevel       = protectLevel;
      next_watchdogEnable     = watchdogEnable;
      next_powerupDelayEnable = powerupDelayEnable;
      next_brownoutEnable     = brownoutEnable;
      next_protectFromAddr    = protectFromAddr;
      next_lowPageWritable    = lowPageWritable;
      next_protectConsistent  = protectConsistent;
      // no run-time path can change these, watchdog included
      if (state == DOW_CAPTURE) begin
         next_oscillatorSelect   = decOsc;
         next_protectLevel       = decProt;
         next_watchdogEnable     = decWdt;
         next_powerupDelayEnable = decPwrt;
         next_brownoutEnable     = decBor;
         next_protectFromAddr    = decFrom;
         next_lowPageWritable    = decLowPage;
         next_protectConsistent  = decConsistent;
      end
   end

   // erased-part values until the first capture, save powerupDelayEnable, which starts clear
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         oscillatorSelect   <= DOW_RC_MODE;
         protectLevel       <= DOW_PROT_NONE;
         watchdogEnable     <= `DOW_RST_WDT;
         powerupDelayEnable <= `DOW_RST_POWERUP_DELAY_TIMER;
         brownoutEnable     <= `DOW_RST_BOR;
         protectFromAddr    <= `DOW_PROT_NONE_FROM;
         lowPageWritable    <= `DOW_RST_LOW_PAGE;
         protectConsistent  <= `DOW_RST_CONSIST;
      end else begin
         oscillatorSelect   <= next_oscillatorSelect;
         protectLevel       <= next_protectLevel;
         watchdogEnable     <= next_watchdogEnable;
         powerupDelayEnable <= next_powerupDelayEnable;
         brownoutEnable     <= next_brownoutEnable;
         protectFromAddr    <= next_protectFromAddr;
         lowPageWritable    <= next_lowPageWritable;
         protectConsistent  <= next_protectConsistent;
      end
   end

   assign crystalMode          = isCrystal(oscillatorSelect);
   assign externalClockAllowed = crystalMode;

   // ==========================================================
   // reset release sequencer
   // one counter serves both timers; 24 bits hold the full power-up count
   logic [23:0] count;
   logic [23:0] next_count;
   logic        oscPrev;
   logic        oscEdge;

   // pin taken as synchronous; rising edge counts one cycle
   assign oscEdge = oscillatorInputPin & ~oscPrev;

   always_comb begin
      next_state = state;
      next_count = count;
      case (state)
         DOW_CAPTURE: begin
            next_count = 24'h000000;
            if (decPwrt) begin
               next_state = DOW_POWERUP_DELAY;
            end else if (isCrystal(decOsc)) begin
               next_state = DOW_OSC_STARTUP;
            end else begin
               next_state = DOW_RUN;
            end
         end
         DOW_POWERUP_DELAY: begin
            next_count = count + 24'h000001;
            if (count == 24'(POWERUP_DELAY_TIMER_CYCLES - 1)) begin
               next_count = 24'h000000;
               next_state = afterDelay(oscillatorSelect);
            end
         end
         DOW_OSC_STARTUP: begin
            if (oscEdge) begin
               next_count = count + 24'h000001;
               if (count == `DOW_OST_EDGES - 24'h000001) begin
                  next_state = DOW_RUN;
               end
            end
         end
         DOW_RUN: begin
            next_count = 24'h000000;
            if (sleepRequest && !externalReset) begin
               next_state = DOW_HALT;
            end
         end
         DOW_HALT: begin
            next_count = 24'h000000;
            if (externalReset) begin
               next_state = DOW_RUN;
            end else if (watchdogWake || interruptWake) begin
               next_state = afterDelay(oscillatorSelect);
            end
         end
         default: begin
            next_state = DOW_CAPTURE;
            next_count = 24'h000000;
         end
      endcase
      // brown-out restarts through the power-up delay
      // and outranks every transition except the one out of capture, halt included
      if (brownoutEnable && brownoutDetect && state != DOW_CAPTURE) begin
         next_state = DOW_POWERUP_DELAY;
         next_count = 24'h000000;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state   <= DOW_CAPTURE;
         count   <= 24'h000000;
         oscPrev <= 1'b0;
      end else begin
         state   <= next_state;
         count   <= next_count;
         oscPrev <= oscillatorInputPin;
      end
   end

   // external reset holds the chip but skips the power-up timers
   assign chipReset  = (state == DOW_CAPTURE) ||
                       (state == DOW_POWERUP_DELAY) ||
                       (state == DOW_OSC_STARTUP) ||
                       (externalReset && state == DOW_RUN);
   assign haltActive = (state == DOW_HALT);

endmodule

// ### dow_pkg.sv
// types shared by the device option word decoder
package dow_pkg;

   typedef enum logic [1:0] {
      DOW_LOW_POWER_CRYSTAL_MODE  = 2'h0,
      DOW_CRYSTAL_RESONATOR_MODE  = 2'h1,
      DOW_HIGH_SPEED_CRYSTAL_MODE = 2'h2,
      DOW_RC_MODE                 = 2'h3
   } dow_osc_t;

   typedef enum logic [1:0] {
      DOW_PROT_ALL        = 2'h0,
      DOW_PROT_UPPER_3_4  = 2'h1,
      DOW_PROT_UPPER_HALF = 2'h2,
      DOW_PROT_NONE       = 2'h3
   } dow_prot_t;

   typedef enum logic [2:0] {
      DOW_CAPTURE,
      DOW_POWERUP_DELAY,
      DOW_OSC_STARTUP,
      DOW_RUN,
      DOW_HALT
   } dow_state_t;

endpackage

// ### dow_programmer.sv
// device programmer model holding the option word array
`timescale 1ns/1ps
module dow_programmer (
   // clock and power-on reset
   input  logic        clk,
   input  logic        rst,
   // programmer port
   output logic        progMode,
   output logic        progWrite,
   output logic [13:0] progAddr,
   output logic [13:0] progData,
   // array
   input  logic        optionWordWrite,
   input  logic [13:0] optionWriteData,
   output logic [13:0] storedWord
);
   // ==========================================
   // array and access
   logic [13:0] pend;
   initial begin
      {progMode, progWrite, progAddr, progData} = 30'h0;
      pend = 14'h3FFF;
      storedWord = 14'h3FFF;
   end
   // new contents reach the decoder only at the next power-up
   always @(posedge clk) begin
      if (optionWordWrite)
         pend <= optionWriteData;
      if (rst)
         storedWord <= pend;
   end
   // c is {paired, protect, brown-out, delay_n, watchdog, oscillator}
   function automatic logic [13:0] mk(input logic [7:0] c);
      return c[7] ? {{3{c[6:5]}}, 1'b1, c[4], c[6:5], c[3:0]}
                  : {{7{c[5]}}, c[4], {2{c[5]}}, c[3:0]};
   endfunction
   // mode only up for the one access, never left on in normal running
   task automatic put(input logic m, wr, input logic [13:0] a, d);
      @(posedge clk);
      progMode <= m;
      progWrite <= wr;
      progAddr <= a;
      progData <= d;
      @(posedge clk);
      progWrite <= 1'b0;
      progMode <= 1'b0;
      #1;
   endtask
endmodule

// ### tb_device_option_word_decode.sv
// self-checking bench for the option word decoder
`timescale 1ns/1ps
module tb_device_option_word_decode;
   import dow_pkg::*;
   // ==========================================
   // signals and tables
   localparam int PW = 20;
   // {paired, protect, brown-out, delay_n, watchdog, oscillator}
   localparam logic [7:0] CFG [5] = '{8'h6F, 8'h08, 8'hC2, 8'hBD, 8'hEF};
   localparam logic [12:0] FROM [4] = '{13'h0, 13'h400, 13'h800, 13'hFFF};
   logic        clk, rst, pairedLayout, progMode, progWrite, testSpaceWrite;
   logic        optionWordWrite, oscillatorInputPin, externalReset, pe, x;
   logic        brownoutDetect, sleepRequest, watchdogWake, interruptWake;
   logic        crystalMode, externalClockAllowed, watchdogEnable;
   logic        powerupDelayEnable, brownoutEnable, lowPageWritable;
   logic        protectConsistent, chipReset, haltActive;
   logic [13:0] storedWord, progAddr, progData, optionWriteData;
   logic [13:0] progReadData, w;
   logic [12:0] protectFromAddr;
   logic [7:0]  c;
   dow_osc_t    oscillatorSelect;
   dow_prot_t   protectLevel;
   int          err_total, checks, cyc, n, lo;

   dow_decoder #(.POWERUP_DELAY_TIMER_CYCLES(PW)) dut (.*);
   dow_programmer prog (.*);

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // free-running external clock: one rising edge every two cycles
   always @(posedge clk) begin
      oscillatorInputPin <= ~oscillatorInputPin;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         summarize();
      end
   end

   task automatic chk(input logic [23:0] g, e);
      checks++;
      if (g !== e) begin
         err_total++;
         $display("unexpected t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic waitRun();
      n = 0;
      while (chipReset !== 1'b0 && n < 5000) begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask

   task automatic summarize();
      if (err_total == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial begin
      rst = 1'b1;
      pairedLayout = 1'b0;
      oscillatorInputPin = 1'b0;
      {externalReset, brownoutDetect, sleepRequest} = 3'h0;
      {watchdogWake, interruptWake} = 2'h0;
      err_total = 0;
      checks = 0;
      cyc = 0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         c = CFG[i];
         w = prog.mk(c);
         w[7] = w[7] && (i < 4);
         pe = !c[3] || c[4];
         x = c[1:0] != 2'h3;
         lo = 1 + (pe ? PW : 0) + (x ? 2048 : 0);
         prog.put(1'b1, 1'b1, 14'h2007, w);
         chk({optionWordWrite, testSpaceWrite, optionWriteData},
             {2'h3, w});
         prog.put(1'b1, 1'b1, 14'h1007, 14'h0);
         chk({optionWordWrite, testSpaceWrite}, 0);
         prog.put(1'b0, 1'b1, 14'h2007, 14'h0);
         chk({optionWordWrite, testSpaceWrite}, 0);
         @(posedge clk);
         rst <= 1'b1;
         pairedLayout <= c[7];
         repeat (6) @(posedge clk);
         rst <= 1'b0;
         waitRun();
         chk(n >= lo - 3 && n <= lo + 6, 1);
         chk({oscillatorSelect, crystalMode, externalClockAllowed,
             watchdogEnable}, {c[1:0], x, x, c[2]});
         chk({powerupDelayEnable, brownoutEnable, protectLevel,
             lowPageWritable, protectConsistent, protectFromAddr},
             {pe, c[4], c[6:5], ~c[7] & ~c[5], 1'b1,
             FROM[c[6:5]]});
         for (int k = 0; k < 3 && i < 2; k++) begin
            @(posedge clk);
            sleepRequest <= 1'b1;
            @(posedge clk);
            sleepRequest <= 1'b0;
            @(posedge clk);
            #1;
            chk(haltActive, 1);
            @(posedge clk);
            {externalReset, watchdogWake, interruptWake} <= 3'h1 << k;
            @(posedge clk);
            {externalReset, watchdogWake, interruptWake} <= 3'h0;
            repeat (2) @(posedge clk);
            #1;
            chk(chipReset, x && k < 2);
            waitRun();
            chk({haltActive, chipReset}, 0);
         end
         if (c[4]) begin
            @(posedge clk);
            brownoutDetect <= 1'b1;
            @(posedge clk);
            brownoutDetect <= 1'b0;
            @(posedge clk);
            #1;
            chk(chipReset, 1);
            waitRun();
            chk(n >= lo - 6 && n <= lo + 6, 1);
         end
      end
      prog.put(1'b1, 1'b0, 14'h2007, 14'h0);
      chk(progReadData, w | 14'h0080);
      // protect copies that disagree: single layout, bit 5 set, bit 4 clear
      w = 14'h3FAF;
      prog.put(1'b1, 1'b1, 14'h2007, w);
      @(posedge clk);
      rst <= 1'b1;
      pairedLayout <= 1'b0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      waitRun();
      chk({protectConsistent, protectLevel, lowPageWritable, protectFromAddr},
          {1'b0, 2'h0, 1'b1, 13'h0});
      summarize();
   end
endmodule
